// ---- crystal_input_buffer_config.sv ----
/*
 * Crystal oscillator and reference input buffer configuration register,
 * with the reference divider and oscillator buffer sequencing behind it.
 * Assumes the serial slave interface delivers byte-enabled word writes
 * synchronous to ref_clk and reports its current mode on serial_mode.
 */
// Notes on behaviour
// - Ratio 2..31 divides the reference; 0 passes it undivided; 1 is reserved.
// - Active-low hold, reset 1, stops divided clock unless the divider is bypassed.
// - Gain code enables zero to three boost amplifiers during startup in oscillator mode; resets to 1.
// - Output terminal capacitance code, 0.42pF steps upward; resets to 0x28.
// - Input terminal capacitance code, equal steps upward; resets to 0x28.
// - Buffer on from startup until power cycle; force-off bit disables it.
// - Three-bit series resistance code limits crystal drive; resets to 4.
// - Select bit: 0 input buffer, 1 crystal oscillator; resets to 1.
// - Input type: 0 differential, 1 single-ended CMOS; resets to 0.
// - Pair select: 0 PMOS low common mode, 1 NMOS higher; resets 1.
// - Register reached over the serial slave; disabled mode blocks writes.
`timescale 1ns/100ps
module crystal_input_buffer_config
(
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic [1:0] serial_mode,
    input wire logic reg_wr_en,
    input wire logic [3:0] reg_byte_en,
    input wire logic [31:0] reg_wr_data,
    output logic [31:0] reg_rd_data,
    input wire logic startup_begin,
    input wire logic startup_done,
    output logic osc_buffer_enable,
    output logic [2:0] gain_amp_enable,
    output logic [5:0] output_terminal_cap_code,
    output logic [5:0] input_terminal_cap_code,
    output logic [2:0] series_resistance_code,
    output logic buffer_dc_bias_enable,
    output logic osc_mode_enable,
    output logic input_buffer_enable,
    output logic buffer_single_ended_select,
    output logic pmos_pair_enable,
    output logic nmos_pair_enable,
    output logic ref_div_clk,
    output logic ref_div_tick,
    output logic ref_div_bypass
);

    // ------------------------------------------------------------------
    // Register storage
    // ------------------------------------------------------------------
    logic [31:0] crystal_config_r;
    logic [31:0] crystal_config_nxt;
    logic [31:0] lane_mask;
    logic access_ok;

    // Field views of the stored word
    logic ref_divider_hold_n;
    logic [4:0] ref_divider_ratio;
    logic [1:0] gain_code;
    logic [5:0] out_cap;
    logic osc_buffer_force_off;
    logic [5:0] in_cap;
    logic [2:0] res_code;
    logic dc_bias;
    logic osc_or_buffer_select;
    logic single_ended;
    logic buffer_input_pair_select;

    // Registered analog control outputs
    logic [2:0] gain_amp_r;
    logic [2:0] gain_amp_nxt;
    logic [5:0] out_cap_r;
    logic [5:0] out_cap_nxt;
    logic [5:0] in_cap_r;
    logic [5:0] in_cap_nxt;
    logic [2:0] res_r;
    logic [2:0] res_nxt;
    logic [5:0] mode_bits_r;
    logic [5:0] mode_bits_nxt;

    // Sequencer status
    logic osc_in_startup;

    // ------------------------------------------------------------------
    // Register write port
    // ------------------------------------------------------------------

    assign access_ok = (serial_mode != crystal_config_pkg::SERIAL_DISABLED);

    // One byte lane per generate entry; the serial slave writes bytewise
    genvar lane;
    generate
        for (lane = 0; lane < 4; lane++)
        begin : g_lane
            assign lane_mask[lane * 8 +: 8] = {8{reg_byte_en[lane]}};
        end
    endgenerate

    // Merge enabled lanes; reserved bits are never stored
    always_comb
    begin
        crystal_config_nxt = crystal_config_r;
        if (reg_wr_en && access_ok)
        begin
            crystal_config_nxt = (crystal_config_r & ~(lane_mask &
                                  crystal_config_pkg::WRITE_MASK)) |
                                 (reg_wr_data & lane_mask &
                                  crystal_config_pkg::WRITE_MASK);
        end
    end

    // Holding register; reset loads every documented default
    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
        begin
            crystal_config_r <= crystal_config_pkg::CONFIG_RESET;
        end
        else
        begin
            crystal_config_r <= crystal_config_nxt;
        end
    end

    // Read data comes straight from the flops; reads have no side effects
    assign reg_rd_data = crystal_config_r;

    // ------------------------------------------------------------------
    // Field extraction
    // ------------------------------------------------------------------
    assign ref_divider_hold_n = crystal_config_r[crystal_config_pkg::HOLD_N_BIT];
    assign ref_divider_ratio =
        crystal_config_r[crystal_config_pkg::RATIO_MSB:crystal_config_pkg::RATIO_LSB];
    assign gain_code =
        crystal_config_r[crystal_config_pkg::GAIN_MSB:crystal_config_pkg::GAIN_LSB];
    assign out_cap =
        crystal_config_r[crystal_config_pkg::OUT_CAP_MSB:crystal_config_pkg::OUT_CAP_LSB];
    assign osc_buffer_force_off = crystal_config_r[crystal_config_pkg::FORCE_OFF_BIT];
    assign in_cap =
        crystal_config_r[crystal_config_pkg::IN_CAP_MSB:crystal_config_pkg::IN_CAP_LSB];
    assign res_code =
        crystal_config_r[crystal_config_pkg::RES_MSB:crystal_config_pkg::RES_LSB];
    assign dc_bias = crystal_config_r[crystal_config_pkg::DC_BIAS_BIT];
    assign osc_or_buffer_select = crystal_config_r[crystal_config_pkg::OSC_SEL_BIT];
    assign single_ended = crystal_config_r[crystal_config_pkg::SINGLE_END_BIT];
    assign buffer_input_pair_select = crystal_config_r[crystal_config_pkg::PAIR_SEL_BIT];

    // ------------------------------------------------------------------
    // Analog control decode
    // ------------------------------------------------------------------

    // Decode the codes into the pins of the analog stage
    always_comb
    begin
        gain_amp_nxt = 3'h0;
        if (osc_in_startup && osc_or_buffer_select)
        begin
            unique case (gain_code)
                2'h0: gain_amp_nxt = 3'h0;
                2'h1: gain_amp_nxt = 3'h1;
                2'h2: gain_amp_nxt = 3'h3;
                2'h3: gain_amp_nxt = 3'h7;
            endcase
        end
        out_cap_nxt = out_cap;
        in_cap_nxt = in_cap;
        res_nxt = res_code;
        mode_bits_nxt[0] = osc_or_buffer_select;
        mode_bits_nxt[1] = !osc_or_buffer_select;
        mode_bits_nxt[2] = dc_bias;
        mode_bits_nxt[3] = single_ended;
        mode_bits_nxt[4] = !buffer_input_pair_select;
        mode_bits_nxt[5] = buffer_input_pair_select;
    end

    // Outputs are registered so the analog pins never see decode glitches
    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
        begin
            gain_amp_r <= 3'h0;
            out_cap_r <= crystal_config_pkg::CONFIG_RESET[
                crystal_config_pkg::OUT_CAP_MSB:crystal_config_pkg::OUT_CAP_LSB];
            in_cap_r <= crystal_config_pkg::CONFIG_RESET[
                crystal_config_pkg::IN_CAP_MSB:crystal_config_pkg::IN_CAP_LSB];
            res_r <= crystal_config_pkg::CONFIG_RESET[
                crystal_config_pkg::RES_MSB:crystal_config_pkg::RES_LSB];
            mode_bits_r <= 6'h21; // Oscillator mode, NMOS pair, differential
        end
        else
        begin
            gain_amp_r <= gain_amp_nxt;
            out_cap_r <= out_cap_nxt;
            in_cap_r <= in_cap_nxt;
            res_r <= res_nxt;
            mode_bits_r <= mode_bits_nxt;
        end
    end

    assign gain_amp_enable = gain_amp_r;
    assign output_terminal_cap_code = out_cap_r;
    assign input_terminal_cap_code = in_cap_r;
    assign series_resistance_code = res_r;
    assign osc_mode_enable = mode_bits_r[0];
    assign input_buffer_enable = mode_bits_r[1];
    assign buffer_dc_bias_enable = mode_bits_r[2];
    assign buffer_single_ended_select = mode_bits_r[3];
    assign pmos_pair_enable = mode_bits_r[4];
    assign nmos_pair_enable = mode_bits_r[5];

    // ------------------------------------------------------------------
    // Oscillator buffer sequencing
    // ------------------------------------------------------------------

    osc_buffer_ctrl u_osc_buffer_ctrl
    (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .startup_begin(startup_begin),
        .startup_done(startup_done),
        .force_off(osc_buffer_force_off),
        .buffer_enable(osc_buffer_enable),
        .in_startup(osc_in_startup)
    );

    // ------------------------------------------------------------------
    // Reference divider
    // ------------------------------------------------------------------

    // ratio and bypass; hold stops the divided clock
    ref_divider u_ref_divider
    (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .ratio(ref_divider_ratio),
        .hold_n(ref_divider_hold_n),
        .div_clk(ref_div_clk),
        .div_tick(ref_div_tick),
        .bypass(ref_div_bypass)
    );

endmodule

// ---- crystal_config_pkg.sv ----
/*
 * Constants shared by the crystal and reference input buffer configuration
 * block: field positions, reset values, masks and the state encoding.
 * Assumes nothing of its surroundings; every user writes package::name.
 */
package crystal_config_pkg;

    // ------------------------------------------------------------------
    // Field positions in the 32-bit configuration word
    // ------------------------------------------------------------------
    localparam int HOLD_N_BIT = 29;
    localparam int RATIO_LSB = 24;
    localparam int RATIO_MSB = 28;
    localparam int GAIN_LSB = 22;
    localparam int GAIN_MSB = 23;
    localparam int OUT_CAP_LSB = 16;
    localparam int OUT_CAP_MSB = 21;
    localparam int FORCE_OFF_BIT = 14;
    localparam int IN_CAP_LSB = 8;
    localparam int IN_CAP_MSB = 13;
    localparam int RES_LSB = 4;
    localparam int RES_MSB = 6;
    localparam int DC_BIAS_BIT = 3;
    localparam int OSC_SEL_BIT = 2;
    localparam int SINGLE_END_BIT = 1;
    localparam int PAIR_SEL_BIT = 0;

    // ------------------------------------------------------------------
    // Widths and special codes
    // ------------------------------------------------------------------
    localparam int RATIO_W = 5;
    localparam int GAIN_W = 2;
    localparam int CAP_W = 6;
    localparam int RES_W = 3;
    localparam int AMP_COUNT = 3;
    localparam logic [4:0] RATIO_BYPASS = 5'h00;
    localparam logic [4:0] RATIO_RESERVED = 5'h01;
    localparam logic [4:0] RATIO_ONE = 5'h01;

    // Writable bits; 31:30, 15 and 7 stay zero
    localparam logic [31:0] WRITE_MASK = 32'h3FFF7F7F;

    // ------------------------------------------------------------------
    // Reset value of the whole word
    // ------------------------------------------------------------------
    localparam logic [31:0] CONFIG_RESET = 32'h20682845;

    // Serial interface mode codes
    localparam logic [1:0] SERIAL_DISABLED = 2'h0;
    localparam logic [1:0] SERIAL_TWO_WIRE = 2'h1;
    localparam logic [1:0] SERIAL_FOUR_WIRE = 2'h2;
    localparam logic [1:0] SERIAL_SMBUS = 2'h3;

    // Oscillator buffer startup states
    typedef enum logic [2:0] {
        BUF_IDLE = 3'h1,
        BUF_STARTUP = 3'h2,
        BUF_RUN = 3'h4
    } buf_state_t;

endpackage

// ---- ref_divider.sv ----
/*
 * High-frequency reference divider. Divides by the ratio code 2..31,
 * passes every cycle when bypassed, otherwise stops low while the hold is asserted.
 * Assumes the ratio and hold inputs come from registers on ref_clk.
 */
`timescale 1ns/100ps
module ref_divider
(
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic [4:0] ratio,
    input wire logic hold_n,
    output logic div_clk,
    output logic div_tick,
    output logic bypass
);

    logic [4:0] count_r;
    logic [4:0] count_nxt;
    logic div_clk_r;
    logic div_clk_nxt;
    logic div_tick_r;
    logic div_tick_nxt;
    logic pass;

    // Code 1 is reserved; it is treated as bypass so the clock never dies
    assign pass = (ratio == crystal_config_pkg::RATIO_BYPASS) ||
                  (ratio == crystal_config_pkg::RATIO_RESERVED);

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    always_comb
    begin
        count_nxt = count_r;
        div_clk_nxt = div_clk_r;
        div_tick_nxt = 1'b0;
        if (pass)
        begin
            // Undivided: a tick every cycle, hold has no effect
            count_nxt = 5'h00;
            div_clk_nxt = ~div_clk_r;
            div_tick_nxt = 1'b1;
        end
        else if (!hold_n)
        begin
            // Held in reset state: count cleared, output stops low
            count_nxt = 5'h00;
            div_clk_nxt = 1'b0;
        end
        else
        begin
            // Compare with >= so a ratio lowered mid-count wraps at once
            if (count_r >= ratio - crystal_config_pkg::RATIO_ONE)
            begin
                count_nxt = 5'h00;
                div_tick_nxt = 1'b1;
            end
            else
            begin
                count_nxt = count_r + crystal_config_pkg::RATIO_ONE;
            end
            // High for the first floor(ratio/2) counts of each period
            div_clk_nxt = (count_nxt < (ratio >> 1));
        end
    end

    // Registers
    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
        begin
            count_r <= 5'h00;
            div_clk_r <= 1'b0;
            div_tick_r <= 1'b0;
        end
        else
        begin
            count_r <= count_nxt;
            div_clk_r <= div_clk_nxt;
            div_tick_r <= div_tick_nxt;
        end
    end

    assign div_clk = div_clk_r;
    assign div_tick = div_tick_r;
    assign bypass = pass;

endmodule

// ---- osc_buffer_ctrl.sv ----
/*
 * Oscillator buffer enable sequencer. Enables the buffer at startup and
 * keeps it on until reset; a debug override forces it off.
 * Assumes startup_begin and startup_done come from the power-up sequencer.
 */
`timescale 1ns/100ps
module osc_buffer_ctrl
(
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic startup_begin,
    input wire logic startup_done,
    input wire logic force_off,
    output logic buffer_enable,
    output logic in_startup
);

    crystal_config_pkg::buf_state_t state_r;
    crystal_config_pkg::buf_state_t state_nxt;
    logic enable_r;
    logic enable_nxt;

    // Sequencer: only reset leaves RUN, standing in for a power cycle
    always_comb
    begin
        state_nxt = state_r;
        unique case (state_r)
            crystal_config_pkg::BUF_IDLE:
                if (startup_begin)
                    state_nxt = crystal_config_pkg::BUF_STARTUP;
            crystal_config_pkg::BUF_STARTUP:
                if (startup_done)
                    state_nxt = crystal_config_pkg::BUF_RUN;
            crystal_config_pkg::BUF_RUN:
                state_nxt = crystal_config_pkg::BUF_RUN;
            default:
                state_nxt = crystal_config_pkg::BUF_IDLE;
        endcase
        enable_nxt = (state_nxt != crystal_config_pkg::BUF_IDLE) && !force_off;
    end

    // Registers
    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
        begin
            state_r <= crystal_config_pkg::BUF_IDLE;
            enable_r <= 1'b0;
        end
        else
        begin
            state_r <= state_nxt;
            enable_r <= enable_nxt;
        end
    end

    assign buffer_enable = enable_r;
    assign in_startup = (state_r == crystal_config_pkg::BUF_STARTUP);

endmodule

// ---- crystal_config_properties.sv ----
/*
 * Concurrent checks on the crystal configuration block, seen from its ports.
 * Assumes only the top module's ports; attached by bind after the module.
 */
`timescale 1ns/100ps
module crystal_config_properties
(
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic [1:0] serial_mode,
    input wire logic reg_wr_en,
    input wire logic [3:0] reg_byte_en,
    input wire logic [31:0] reg_wr_data,
    input wire logic [31:0] reg_rd_data,
    input wire logic osc_buffer_enable,
    input wire logic [2:0] gain_amp_enable,
    input wire logic [5:0] output_terminal_cap_code,
    input wire logic [5:0] input_terminal_cap_code,
    input wire logic osc_mode_enable,
    input wire logic input_buffer_enable,
    input wire logic pmos_pair_enable,
    input wire logic nmos_pair_enable,
    input wire logic ref_div_tick,
    input wire logic ref_div_bypass
);
    // ------------------------------------------------------------------
    // Clocking and helpers
    // ------------------------------------------------------------------
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    // Stored ratio 3 with hold released; the period check needs it steady
    logic ratio3;
    assign ratio3 = reg_rd_data[29:24] == 6'h23;

    // ------------------------------------------------------------------
    // Register word
    // ------------------------------------------------------------------
    reserved_read_zero_a: assert property (
        reg_rd_data[31:30] == 2'h0 && !reg_rd_data[15] && !reg_rd_data[7])
        else $error("reserved bit reads one");
    full_write_taken_a: assert property (
        reg_wr_en && serial_mode != 2'h0 && reg_byte_en == 4'hF
        |=> reg_rd_data == ($past(reg_wr_data) & 32'h3FFF7F7F))
        else $error("full word write not stored");
    disabled_write_refused_a: assert property (
        reg_wr_en && serial_mode == 2'h0 |=> $stable(reg_rd_data))
        else $error("write taken while serial slave disabled");
    idle_word_stable_a: assert property (
        !reg_wr_en |=> $stable(reg_rd_data))
        else $error("stored word changed without a write");

    // ------------------------------------------------------------------
    // Decoded outputs follow the stored word one cycle later
    // ------------------------------------------------------------------
    cap_codes_follow_a: assert property (
        $past(rst_n) |-> output_terminal_cap_code == $past(reg_rd_data[21:16])
        && input_terminal_cap_code == $past(reg_rd_data[13:8]))
        else $error("capacitance code differs from stored word");
    mode_pair_decode_a: assert property (
        $past(rst_n) |-> osc_mode_enable == $past(reg_rd_data[2])
        && input_buffer_enable != osc_mode_enable
        && nmos_pair_enable == $past(reg_rd_data[0]) && pmos_pair_enable != nmos_pair_enable)
        else $error("mode or pair select decode wrong");

    // ------------------------------------------------------------------
    // Divider
    // ------------------------------------------------------------------
    bypass_every_cycle_a: assert property (
        $past(rst_n) && $past(ref_div_bypass) |-> ref_div_tick)
        else $error("bypassed divider missed a tick");
    ratio_three_period_a: assert property (
        (ratio3[*4] ##0 ref_div_tick) ##1 ratio3[*3]
        |-> ref_div_tick && !$past(ref_div_tick) && !$past(ref_div_tick, 2))
        else $error("divide by three period wrong");
    hold_stops_ticks_a: assert property (
        (!reg_rd_data[29] && reg_rd_data[28:25] != 4'h0)[*3] |-> !ref_div_tick)
        else $error("held divider still ticking");

    // ------------------------------------------------------------------
    // Oscillator buffer and gain boost
    // ------------------------------------------------------------------
    force_off_wins_a: assert property (
        reg_rd_data[14] ##1 reg_rd_data[14] |-> !osc_buffer_enable)
        else $error("buffer enabled while forced off");
    buffer_stays_on_a: assert property (
        osc_buffer_enable && !reg_rd_data[14] ##1 !reg_rd_data[14] |-> osc_buffer_enable)
        else $error("buffer enable dropped without force off");
    gain_off_buffer_a: assert property (
        (!osc_mode_enable)[*3] |-> gain_amp_enable == 3'h0)
        else $error("boost amplifiers on in input buffer mode");

    // Main scenarios reached
    cover property (reg_wr_en && serial_mode == 2'h0);
    cover property (ref_div_tick && !ref_div_bypass);
    cover property (gain_amp_enable == 3'h7);
    cover property ($rose(osc_buffer_enable));
endmodule

bind crystal_input_buffer_config crystal_config_properties chk_u
(
    .ref_clk, .rst_n, .serial_mode, .reg_wr_en, .reg_byte_en, .reg_wr_data, .reg_rd_data,
    .osc_buffer_enable, .gain_amp_enable, .output_terminal_cap_code,
    .input_terminal_cap_code, .osc_mode_enable, .input_buffer_enable,
    .pmos_pair_enable, .nmos_pair_enable, .ref_div_tick, .ref_div_bypass
);

// ---- tb_crystal_input_buffer_config.sv ----
/*
 * Self-checking bench for the crystal configuration block.
 * Assumes the bound checker file is compiled alongside; drives all ports.
 */
`timescale 1ns/100ps
module tb_crystal_input_buffer_config;
    // ------------------------------------------------------------------
    // Stimulus and observed signals
    // ------------------------------------------------------------------
    typedef struct {logic [1:0] m; logic [3:0] be; logic [31:0] d; logic [31:0] q;} row_t;
    logic ref_clk = 1'b0;
    logic rst_n = 1'b0;
    logic [1:0] serial_mode = 2'h1;
    logic reg_wr_en = 1'b0;
    logic [3:0] reg_byte_en = 4'h0;
    logic [31:0] reg_wr_data = 32'h0;
    logic startup_begin = 1'b0;
    logic startup_done = 1'b0;
    logic [31:0] reg_rd_data;
    logic osc_buffer_enable, buffer_dc_bias_enable, osc_mode_enable, input_buffer_enable;
    logic buffer_single_ended_select, pmos_pair_enable, nmos_pair_enable;
    logic ref_div_clk, ref_div_tick, ref_div_bypass;
    logic [2:0] gain_amp_enable, series_resistance_code;
    logic [5:0] output_terminal_cap_code, input_terminal_cap_code;
    int miscompares = 0;
    int n_checks = 0;
    int ticks, highs;
    row_t rows[6];
    logic [4:0] ratios[3] = '{5'h02, 5'h03, 5'h1F};
    logic [2:0] therm[4] = '{3'h0, 3'h1, 3'h3, 3'h7};

    crystal_input_buffer_config uut
    (
        .ref_clk(ref_clk), .rst_n(rst_n), .serial_mode(serial_mode),
        .reg_wr_en(reg_wr_en), .reg_byte_en(reg_byte_en), .reg_wr_data(reg_wr_data),
        .reg_rd_data(reg_rd_data), .startup_begin(startup_begin),
        .startup_done(startup_done), .osc_buffer_enable(osc_buffer_enable),
        .gain_amp_enable(gain_amp_enable), .output_terminal_cap_code(output_terminal_cap_code),
        .input_terminal_cap_code(input_terminal_cap_code),
        .series_resistance_code(series_resistance_code),
        .buffer_dc_bias_enable(buffer_dc_bias_enable), .osc_mode_enable(osc_mode_enable),
        .input_buffer_enable(input_buffer_enable),
        .buffer_single_ended_select(buffer_single_ended_select),
        .pmos_pair_enable(pmos_pair_enable), .nmos_pair_enable(nmos_pair_enable),
        .ref_div_clk(ref_div_clk), .ref_div_tick(ref_div_tick), .ref_div_bypass(ref_div_bypass)
    );

    // 125 MHz reference
    always #4 ref_clk = ~ref_clk;

    // ------------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------------
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("mismatch %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    // One write; the strobe drops at the taking edge
    task automatic wr(input logic [1:0] m, input logic [3:0] be, input logic [31:0] d);
        @(posedge ref_clk);
        serial_mode <= m;
        reg_byte_en <= be;
        reg_wr_data <= d;
        reg_wr_en <= 1'b1;
        @(posedge ref_clk);
        reg_wr_en <= 1'b0;
    endtask

    // Step n edges, then let that edge's updates land
    task automatic settle(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask

    // Synchronous reset for five edges
    task automatic do_reset();
        @(posedge ref_clk);
        rst_n <= 1'b0;
        repeat (5) @(posedge ref_clk);
        rst_n <= 1'b1;
        #1;
    endtask

    // Decoded configuration outputs packed for one compare
    function automatic logic [31:0] dec();
        return {10'h0, osc_buffer_enable, output_terminal_cap_code, input_terminal_cap_code,
            series_resistance_code, osc_mode_enable, input_buffer_enable,
            buffer_single_ended_select, pmos_pair_enable, nmos_pair_enable,
            buffer_dc_bias_enable};
    endfunction

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial
    begin
        // Lane writes; each row builds on the word left by the one before
        rows[0] = '{2'h1, 4'hF, 32'hFFFFFFFF, 32'h3FFF7F7F};
        rows[1] = '{2'h2, 4'h1, 32'h00000000, 32'h3FFF7F00};
        rows[2] = '{2'h3, 4'h6, 32'h12345678, 32'h3F345600};
        rows[3] = '{2'h0, 4'hF, 32'h00000000, 32'h3F345600};
        rows[4] = '{2'h1, 4'h8, 32'hC0000000, 32'h00345600};
        rows[5] = '{2'h1, 4'hF, 32'h00C03A3E, 32'h00C03A3E};
        do_reset();
        chk("reset word", reg_rd_data, 32'h20682845);
        chk("reset outputs", dec(), {10'h0, 1'b0, 6'h28, 6'h28, 3'h4, 6'b100010});
        $display("test reset done");
        foreach (rows[i])
        begin
            wr(rows[i].m, rows[i].be, rows[i].d);
            settle(0);
            chk("stored word", reg_rd_data, rows[i].q);
        end
        settle(1);
        chk("osc outputs", dec(), {10'h0, 1'b0, 6'h00, 6'h3A, 3'h3, 6'b101101});
        wr(2'h1, 4'hF, 32'h00000000);
        settle(1);
        chk("buffer outputs", dec(), {10'h0, 1'b0, 6'h00, 6'h00, 3'h0, 6'b010100});
        $display("test register rows done");

        // Divide ratios: six periods hold exactly six ticks whatever the phase
        foreach (ratios[i])
        begin
            wr(2'h1, 4'hF, {3'b001, ratios[i], 24'h0});
            settle(6);
            ticks = 0;
            highs = 0;
            repeat (6 * ratios[i])
            begin
                settle(1);
                ticks += (ref_div_tick === 1'b1);
                highs += (ref_div_clk === 1'b1);
            end
            chk("ticks per six periods", ticks, 6);
            chk("clock high cycles", highs, 6 * (ratios[i] >> 1));
        end
        // Held divider is silent; bypass ignores the hold
        wr(2'h1, 4'hF, 32'h03000000);
        settle(4);
        ticks = 0;
        repeat (30)
        begin
            settle(1);
            ticks += (ref_div_tick === 1'b1);
        end
        chk("held ticks", ticks, 0);
        chk("held clock low", ref_div_clk, 1'b0);
        wr(2'h1, 4'hF, 32'h00000000);
        settle(4);
        chk("bypass flag", ref_div_bypass, 1'b1);
        chk("bypass tick", ref_div_tick, 1'b1);
        $display("test divider done");

        // Each boost code, one startup per reset
        foreach (therm[g])
        begin
            do_reset();
            @(posedge ref_clk);
            startup_done <= 1'b1;
            @(posedge ref_clk);
            startup_done <= 1'b0;
            settle(2);
            chk("done ignored in idle", osc_buffer_enable, 1'b0);
            wr(2'h1, 4'hF, {8'h20, g[1:0], 22'h000004});
            @(posedge ref_clk);
            startup_begin <= 1'b1;
            @(posedge ref_clk);
            startup_begin <= 1'b0;
            settle(2);
            chk("buffer on at startup", osc_buffer_enable, 1'b1);
            chk("boost amplifiers", gain_amp_enable, therm[g]);
        end
        @(posedge ref_clk);
        startup_done <= 1'b1;
        @(posedge ref_clk);
        startup_done <= 1'b0;
        settle(3);
        chk("boost after startup", gain_amp_enable, 3'h0);
        chk("buffer kept on", osc_buffer_enable, 1'b1);
        wr(2'h1, 4'hF, 32'h20C04004);
        settle(2);
        chk("buffer forced off", osc_buffer_enable, 1'b0);
        do_reset();
        chk("second reset word", reg_rd_data, 32'h20682845);
        $display("test oscillator buffer done");
        tally_and_finish();
    end
endmodule
